// [pkg/caa_pkg.sv]
// package: constants, types and mode decode for the counter array compare block
package caa_pkg;
  // channel count default
  localparam int NCH_DEF = 6;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] CNT_OFS   = 8'h08;
  localparam logic [7:0] CH_BASE   = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] MODE_OFS  = 8'h00;
  // compare low byte and high byte sit in words of their own, so word-only masters can write them apart
  localparam logic [7:0] CMP_OFS   = 8'h04;
  localparam logic [7:0] CMPH_OFS  = 8'h08;
  // status field positions
  localparam int STAT_COF_BIT = 0;
  localparam int STAT_POF_BIT = 1;
  localparam int STAT_MEF_LSB = 8;
  // reset values
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [5:0]  MODE_RST = 6'h00;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [10:0] RLD_RST  = 11'h000;
  // prescaler terminal counts
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  // timebase select codes
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_SYS   = 3'h4;
  // cycle length select code for 8-bit cycles
  localparam logic [1:0] CLSEL_8 = 2'h0;

  typedef struct packed {
    logic       reload_access_select;
    logic [1:0] cycle_length_select;
    logic       partial_irq_enable;
    logic       overflow_irq_enable;
    logic [2:0] timebase_select;
    logic       run;
  } caa_ctrl_type;

  typedef struct packed {
    logic wide_pulse_enable;
    logic compare_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_mode_enable;
    logic module_irq_enable;
  } caa_mode_type;

  typedef enum {CAA_OFF, CAA_SWT, CAA_HSO, CAA_FRQ, CAA_PWM8, CAA_PWMN, CAA_PWM16} caa_op_type;

  // operating mode from channel mode bits and the shared cycle length
  function automatic caa_op_type caa_decode(input caa_mode_type m, input logic [1:0] cl);
    if (m.pulse_mode_enable && m.toggle_enable) return CAA_FRQ;
    if (m.pulse_mode_enable && m.wide_pulse_enable) return CAA_PWM16;
    if (m.pulse_mode_enable) return (cl == CLSEL_8) ? CAA_PWM8 : CAA_PWMN;
    if (m.toggle_enable && m.match_flag_enable) return CAA_HSO;
    if (m.match_flag_enable) return CAA_SWT;
    return CAA_OFF;
  endfunction

  // mask of the low n counter bits for the shared cycle length
  function automatic logic [10:0] caa_nmask(input logic [1:0] cl);
    case (cl)
      2'h0:    return 11'h0ff;
      2'h1:    return 11'h1ff;
      2'h2:    return 11'h3ff;
      default: return 11'h7ff;
    endcase
  endfunction
endpackage

// [core/caa_compare_pwm.sv]
// counter array compare, toggle and pwm channels behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module caa_compare_pwm #(
  parameter int NCH = caa_pkg::NCH_DEF
) (
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic            hready,
  input  wire logic [31:0]     hwdata,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // external timebase pin
  input  wire logic            ext_tick_pin,
  // channel pins and interrupt request
  output logic [NCH-1:0]       channel_output_pin,
  output logic                 irq
);

  caa_pkg::caa_ctrl_type ctrl;
  caa_pkg::caa_mode_type mode [NCH];
  caa_pkg::caa_op_type   op [NCH];
  logic [15:0]           cmp [NCH];
  logic [15:0]           next_cmp [NCH];
  logic [10:0]           rld [NCH];
  logic [NCH-1:0]        next_out;
  logic [NCH-1:0]        set_evt;
  logic [NCH-1:0]        m16;
  logic [NCH-1:0]        sw_lo;
  logic [NCH-1:0]        sw_hi;
  logic [NCH-1:0]        sw_mode;
  logic [NCH-1:0]        module_event_flag;
  logic [NCH-1:0]        clr_evt;
  logic [15:0]           cnt;
  logic [15:0]           ncnt;
  logic [3:0]            pre;
  logic                  tick;
  logic                  ovf16;
  logic                  lovf;
  logic                  povf;
  logic [10:0]           nmask;
  logic                  counter_overflow_flag;
  logic                  partial_overflow_flag;
  logic                  s1;
  logic                  s2;
  logic                  s3;
  logic                  ext_lvl;
  logic                  ext_fall;
  logic                  take;
  logic                  wr_q;
  logic [7:0]            addr_q;
  logic [3:0]            be_q;
  logic [31:0]           next_rdata;

  // byte lanes of a transfer from size and low address bits
  function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
    case (sz)
      3'h0:    return 4'(4'h1 << a);
      3'h1:    return a[1] ? 4'hc : 4'h3;
      default: return 4'hf;
    endcase
  endfunction

  // byte address of a channel register
  function automatic logic [7:0] ch_addr(input int n, input logic [7:0] ofs);
    return 8'(caa_pkg::CH_BASE + n * caa_pkg::CH_STRIDE + ofs);
  endfunction

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && htrans[1] && hready;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
      be_q   <= 4'h0;
    end else begin
      wr_q   <= take && hwrite;
      addr_q <= haddr[7:0];
      be_q   <= lanes(hsize, haddr[1:0]);
    end
  end

  // read mux, looked up in the address phase so hrdata is a flop
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      caa_pkg::CTRL_OFS: next_rdata = {23'h0, ctrl};
      caa_pkg::STAT_OFS: begin
        next_rdata[caa_pkg::STAT_COF_BIT] = counter_overflow_flag;
        next_rdata[caa_pkg::STAT_POF_BIT] = partial_overflow_flag;
        next_rdata[caa_pkg::STAT_MEF_LSB +: NCH] = module_event_flag;
      end
      caa_pkg::CNT_OFS: next_rdata = {16'h0, cnt};
      default: ;
    endcase
    for (int n = 0; n < NCH; n++) begin
      if (haddr[7:0] == ch_addr(n, caa_pkg::MODE_OFS)) next_rdata = {26'h0, mode[n]};
      if (haddr[7:0] == ch_addr(n, caa_pkg::CMP_OFS) || haddr[7:0] == ch_addr(n, caa_pkg::CMPH_OFS)) begin
        next_rdata = ctrl.reload_access_select ? {21'h0, rld[n]} : {16'h0, cmp[n]};
      end
    end
  end

  // read data register; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (take && !hwrite) hrdata <= next_rdata;
  end

  // data phase write strobes per channel
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      sw_mode[n] = wr_q && be_q[0] && addr_q == ch_addr(n, caa_pkg::MODE_OFS);
      sw_lo[n]   = wr_q && be_q[0] && addr_q == ch_addr(n, caa_pkg::CMP_OFS);
      sw_hi[n]   = wr_q && be_q[0] && addr_q == ch_addr(n, caa_pkg::CMPH_OFS);
    end
  end

  // global control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl <= caa_pkg::CTRL_RST;
    else if (wr_q && addr_q == caa_pkg::CTRL_OFS) begin
      if (be_q[0]) ctrl[7:0] <= hwdata[7:0];
      if (be_q[1]) ctrl[8] <= hwdata[8];
    end
  end

  // external timebase: three flops, a falling level counts once s2 and s3 agree low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      ext_lvl <= 1'b1;
    end else begin
      s1 <= ext_tick_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) ext_lvl <= s3;
    end
  end
  assign ext_fall = ext_lvl && (s2 == s3) && !s3;

  // prescaler for the divided system clock timebases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pre <= 4'h0;
    else if (!ctrl.run) pre <= 4'h0;
    else if (ctrl.timebase_select == caa_pkg::TB_DIV4 && pre == caa_pkg::DIV4_LAST) pre <= 4'h0;
    else if (pre == caa_pkg::DIV12_LAST) pre <= 4'h0;
    else pre <= pre + 4'h1;
  end

  // timebase tick selection
  always_comb begin
    case (ctrl.timebase_select)
      caa_pkg::TB_DIV12: tick = ctrl.run && pre == caa_pkg::DIV12_LAST;
      caa_pkg::TB_DIV4:  tick = ctrl.run && pre == caa_pkg::DIV4_LAST;
      caa_pkg::TB_SYS:   tick = ctrl.run;
      default:           tick = ctrl.run && ext_fall; // other sources arrive on the pin
    endcase
  end

  // shared counter and its overflow points
  assign ncnt  = cnt + 16'h0001;
  assign nmask = caa_pkg::caa_nmask(ctrl.cycle_length_select);
  assign ovf16 = tick && cnt == 16'hffff;
  assign lovf  = tick && cnt[7:0] == 8'hff;
  assign povf  = tick && (cnt[10:0] & nmask) == nmask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 16'h0000;
    else if (tick) cnt <= ncnt;
  end

  // per channel compare, toggle and pwm next state
  always_comb begin
    logic [7:0]  eff8;
    logic [10:0] effn;
    logic        hit;
    logic        en;
    eff8 = 8'h00;
    effn = 11'h000;
    hit  = 1'b0;
    en   = 1'b0;
    for (int n = 0; n < NCH; n++) begin
      op[n]       = caa_pkg::caa_decode(mode[n], ctrl.cycle_length_select);
      en          = mode[n].compare_enable;
      m16[n]      = tick && ncnt == cmp[n];
      next_cmp[n] = cmp[n];
      next_out[n] = channel_output_pin[n];
      set_evt[n]  = 1'b0;
      case (op[n])
        caa_pkg::CAA_SWT: set_evt[n] = en && m16[n];
        caa_pkg::CAA_HSO: begin
          // a cleared compare enable leaves the pin where it is
          if (en && m16[n]) next_out[n] = !channel_output_pin[n];
          set_evt[n] = en && m16[n];
        end
        caa_pkg::CAA_FRQ: begin
          // 8-bit add wraps, so a zero high byte gives 256 ticks
          if (en && tick && ncnt[7:0] == cmp[n][7:0]) begin
            next_out[n]      = !channel_output_pin[n];
            next_cmp[n][7:0] = cmp[n][7:0] + cmp[n][15:8];
          end
          set_evt[n] = en && mode[n].match_flag_enable && m16[n];
        end
        caa_pkg::CAA_PWM8: begin
          eff8 = lovf ? cmp[n][15:8] : cmp[n][7:0];
          if (lovf) next_cmp[n][7:0] = cmp[n][15:8];
          hit = tick && ncnt[7:0] == eff8;
          // match beats overflow so a zero reload gives full duty
          if (!en) next_out[n] = 1'b0;
          else if (hit) next_out[n] = 1'b1;
          else if (lovf) next_out[n] = 1'b0;
          set_evt[n] = en && mode[n].match_flag_enable && hit;
        end
        caa_pkg::CAA_PWMN: begin
          effn = povf ? rld[n] : cmp[n][10:0];
          if (povf) next_cmp[n] = {5'h00, rld[n]};
          hit = tick && (ncnt[10:0] & nmask) == (effn & nmask);
          if (!en) next_out[n] = 1'b0;
          else if (hit) next_out[n] = 1'b1;
          else if (povf) next_out[n] = 1'b0;
          set_evt[n] = en && mode[n].match_flag_enable && hit;
        end
        caa_pkg::CAA_PWM16: begin
          if (!en) next_out[n] = 1'b0;
          else if (m16[n]) next_out[n] = 1'b1;
          else if (ovf16) next_out[n] = 1'b0;
          set_evt[n] = en && mode[n].match_flag_enable && m16[n];
        end
        default: ;
      endcase
    end
  end

  // channel mode, compare and reload registers; software beats hardware updates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int n = 0; n < NCH; n++) begin
        mode[n] <= caa_pkg::MODE_RST;
        cmp[n]  <= caa_pkg::CMP_RST;
        rld[n]  <= caa_pkg::RLD_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (sw_mode[n]) mode[n] <= hwdata[5:0];
        if (sw_lo[n] || sw_hi[n]) begin
          if (ctrl.reload_access_select) begin
            if (sw_lo[n]) rld[n][7:0] <= hwdata[7:0];
            if (sw_hi[n]) rld[n][10:8] <= hwdata[2:0];
          end else begin
            if (sw_lo[n]) cmp[n][7:0] <= hwdata[7:0];
            if (sw_hi[n]) cmp[n][15:8] <= hwdata[7:0];
          end
          // low and high bytes have separate addresses, so only one strobe fires per write
          mode[n].compare_enable <= sw_hi[n];
        end else begin
          cmp[n] <= next_cmp[n];
        end
      end
    end
  end

  // channel pins come straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) channel_output_pin <= '0;
    else channel_output_pin <= next_out;
  end

  // status flags: write one to clear, a set in the same cycle wins
  assign clr_evt = (wr_q && addr_q == caa_pkg::STAT_OFS && be_q[1]) ?
                   hwdata[caa_pkg::STAT_MEF_LSB +: NCH] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_event_flag     <= '0;
      counter_overflow_flag <= 1'b0;
      partial_overflow_flag <= 1'b0;
    end else begin
      module_event_flag <= (module_event_flag & ~clr_evt) | set_evt;
      if (ovf16) counter_overflow_flag <= 1'b1;
      else if (wr_q && addr_q == caa_pkg::STAT_OFS && be_q[0] && hwdata[caa_pkg::STAT_COF_BIT])
        counter_overflow_flag <= 1'b0;
      if (povf) partial_overflow_flag <= 1'b1;
      else if (wr_q && addr_q == caa_pkg::STAT_OFS && be_q[0] && hwdata[caa_pkg::STAT_POF_BIT])
        partial_overflow_flag <= 1'b0;
    end
  end

  // interrupt request from enabled flags
  always_comb begin
    irq = (counter_overflow_flag && ctrl.overflow_irq_enable)
       || (partial_overflow_flag && ctrl.partial_irq_enable);
    for (int n = 0; n < NCH; n++) begin
      irq = irq || (module_event_flag[n] && mode[n].module_irq_enable);
    end
  end

  // checks on channel 0 and the shared counter
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hso_match;
    op[0] == caa_pkg::CAA_HSO && mode[0].compare_enable && m16[0] && !sw_lo[0] && !sw_hi[0];
  endsequence

  property p_swt_flag;
    op[0] == caa_pkg::CAA_SWT && mode[0].compare_enable && tick && ncnt == cmp[0] |=> module_event_flag[0];
  endproperty
  a_swt_flag: assert property (p_swt_flag) else $error("timer match did not set flag");

  property p_flag_sticky;
    module_event_flag[0] && !clr_evt[0] |=> module_event_flag[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("event flag cleared by hardware");

  property p_lo_clears;
    sw_lo[0] && !sw_hi[0] |=> !mode[0].compare_enable ##1 (sw_hi[0] || !mode[0].compare_enable);
  endproperty
  a_lo_clears: assert property (p_lo_clears) else $error("low byte write kept compare enable");

  property p_hi_sets;
    sw_hi[0] |=> mode[0].compare_enable;
  endproperty
  a_hi_sets: assert property (p_hi_sets) else $error("high byte write left compare off");

  property p_hso_toggle;
    s_hso_match |=> channel_output_pin[0] != $past(channel_output_pin[0]) && module_event_flag[0];
  endproperty
  a_hso_toggle: assert property (p_hso_toggle) else $error("high-speed output missed toggle");

  property p_hold_off;
    op[0] == caa_pkg::CAA_HSO && !mode[0].compare_enable |=> $stable(channel_output_pin[0]);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("disabled toggle output moved");

  property p_pwm_zero;
    (op[0] == caa_pkg::CAA_PWM8 || op[0] == caa_pkg::CAA_PWMN || op[0] == caa_pkg::CAA_PWM16)
      && !mode[0].compare_enable |=> !channel_output_pin[0];
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("pwm output high with compare off");

  property p_pwm8_reload;
    op[0] == caa_pkg::CAA_PWM8 && lovf && !sw_lo[0] && !sw_hi[0] |=> cmp[0][7:0] == $past(cmp[0][15:8]);
  endproperty
  a_pwm8_reload: assert property (p_pwm8_reload) else $error("8-bit pwm reload missed");

  property p_pof;
    povf |=> partial_overflow_flag;
  endproperty
  a_pof: assert property (p_pof) else $error("partial overflow flag not set");

  property p_wrap;
    ovf16 |=> counter_overflow_flag && cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap not flagged");

  property p_pwm16_fall;
    op[0] == caa_pkg::CAA_PWM16 && mode[0].compare_enable && ovf16 && !m16[0] |=> !channel_output_pin[0];
  endproperty
  a_pwm16_fall: assert property (p_pwm16_fall) else $error("16-bit pwm did not fall on wrap");

endmodule // caa_compare_pwm
`default_nettype wire

// [testbench/caa_ext_model.sv]
// far-side model: external tick source feeding the counter timebase
`timescale 1ns/1ps
`default_nettype none
module caa_ext_model (
  // clock
  input  wire logic hclk,
  // falling edge per tick, idles high
  output logic      ext_tick_pin
);
  initial ext_tick_pin = 1'b1;
  // n ticks, wide pulses so the pin synchroniser sees each one
  task automatic step(input int n);
    repeat (n) begin
      @(posedge hclk);
      ext_tick_pin <= 1'b0; // one tick, one counter step
      repeat (3) @(posedge hclk);
      ext_tick_pin <= 1'b1;
      repeat (3) @(posedge hclk);
    end
    // let the last tick cross the synchroniser
    repeat (6) @(posedge hclk);
  endtask
endmodule // caa_ext_model
`default_nettype wire

// [testbench/tb_counter_array_compare_pwm.sv]
// testbench for the counter array compare and pwm block
`timescale 1ns/1ps
`default_nettype none
module tb_counter_array_compare_pwm;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  wire logic   hready;
  logic [31:0] hwdata;
  logic        hresp;
  logic [31:0] hrdata;
  wire logic   ext_tick_pin;
  logic [5:0]  channel_output_pin;
  logic        irq;
  int          fail_count;
  int          comparisons;
  logic [31:0] r;
  // reset values and an unmapped address, {address, expected}
  logic [39:0] rows [6] = '{{8'h00, 32'h0}, {8'h04, 32'h0}, {8'h08, 32'h0},
                            {8'h10, 32'h0}, {8'h14, 32'h0}, {8'hfc, 32'h0}};

  caa_compare_pwm dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .ext_tick_pin(ext_tick_pin),
    .channel_output_pin(channel_output_pin), .irq(irq));
  caa_ext_model ext (.hclk(hclk), .ext_tick_pin(ext_tick_pin));

  // 100 mhz clock
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  // verdict, reached from the end and from any timeout
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // register value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pin or irq level compare, sampled mid-cycle where outputs are settled
  task automatic chkp(input string nm, input int i, input logic e);
    logic g;
    @(negedge hclk);
    g = (i == 6) ? irq : channel_output_pin[i];
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
    @(posedge hclk);
  endtask

  // one ahb-lite single word transfer; entered just after a rising edge
  task automatic bus(input logic s, input logic [1:0] t, input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= s;
    haddr  <= a;
    htrans <= t;
    hwrite <= w;
    hsize  <= 3'h2;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 100) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // selected nonseq word write to a decoded byte address
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, 2'h2, 1'b1, {24'h000000, a}, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b1, 2'h2, 1'b0, {24'h000000, a}, 32'h0, x);
    chk(nm, e, x);
  endtask

  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) rdc("reset_value", rows[i][39:32], rows[i][31:0]);
    // ch0 mode by a seq transfer with upper address bits set, which are not decoded
    bus(1'b1, 2'h3, 1'b1, 32'hffff_ff10, 32'h19, r);
    // low then high compare writes steer compare enable, ch0 software timer at 5
    wr(8'h14, 32'h05);
    // an unselected write must be ignored
    bus(1'b0, 2'h2, 1'b1, 32'h0000_0010, 32'h00, r);
    rdc("mode0", 8'h10, 32'h09);
    wr(8'h18, 32'h00);
    rdc("mode0", 8'h10, 32'h19);
    rdc("cmp0", 8'h14, 32'h0005);
    // ch1 high speed at 3, ch2 frequency step 4 from 2, ch3 8-bit pwm at 0x80
    wr(8'h20, 32'h1c);
    wr(8'h24, 32'h03);
    wr(8'h28, 32'h00);
    wr(8'h30, 32'h16);
    wr(8'h34, 32'h02);
    wr(8'h38, 32'h04);
    wr(8'h40, 32'h1a);
    wr(8'h44, 32'h80);
    wr(8'h48, 32'h80);
    wr(8'h00, 32'h07);
    ext.step(2);
    chkp("pin2", 2, 1'b1);
    chkp("pin1", 1, 1'b0);
    ext.step(1);
    chkp("pin1", 1, 1'b1);
    ext.step(2);
    rdc("stat", 8'h04, 32'h300);
    chkp("irq", 6, 1'b1);
    ext.step(1);
    chkp("pin2", 2, 1'b0);
    rdc("stat", 8'h04, 32'h300);
    wr(8'h04, 32'h100);
    rdc("stat", 8'h04, 32'h200);
    chkp("irq", 6, 1'b0);
    // low byte only disables ch1 compare, pin must hold over the match at 8
    wr(8'h24, 32'h08);
    ext.step(2);
    chkp("pin1", 1, 1'b1);
    ext.step(8'h78);
    chkp("pin3", 3, 1'b1);
    rdc("stat", 8'h04, 32'ha00);
    wr(8'h48, 32'h40);
    ext.step(8'h80);
    chkp("pin3", 3, 1'b0);
    rdc("stat", 8'h04, 32'ha02);
    rdc("cmp3", 8'h44, 32'h4040);
    ext.step(8'h40);
    chkp("pin3", 3, 1'b1);
    wr(8'h44, 32'h00);
    // compare enable drops at the write edge, the pin one edge later
    @(posedge hclk);
    chkp("pin3", 3, 1'b0);
    // 9-bit cycle, reload register reached through the compare address
    wr(8'h00, 32'h147);
    wr(8'h44, 32'h10);
    wr(8'h48, 32'h00);
    rdc("rld3", 8'h44, 32'h0010);
    wr(8'h00, 32'h047);
    rdc("cmp3", 8'h44, 32'h4000);
    wr(8'h04, 32'h802);
    ext.step(8'hc0);
    chkp("pin3", 3, 1'b0);
    rdc("stat", 8'h04, 32'h202);
    rdc("cmp3", 8'h44, 32'h0010);
    ext.step(8'h10);
    chkp("pin3", 3, 1'b1);
    // reset in mid-run clears pins and irq
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chkp("pin3_rst", 3, 1'b0);
    chkp("irq_rst", 6, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctrl_rst", 8'h00, 32'h0);
    end_of_test();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge hclk);
    fail_count++;
    end_of_test();
  end
endmodule // tb_counter_array_compare_pwm
`default_nettype wire
